// [rtl/i2c_flag_pkg.sv]
// shared constants for the two-wire port status flag block
package i2c_flag_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int STAT_W = 16;
    localparam int BYTE_W = 8;
    localparam int IRQ_W = 5;

    localparam logic [7:0] OFS_STATUS = 8'h00;
    localparam logic [7:0] OFS_TX_BUF = 8'h04;
    localparam logic [7:0] OFS_RX_BUF = 8'h08;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h0c;
    localparam logic [7:0] OFS_IRQ_CLR = 8'h10;
    localparam logic [7:0] OFS_IRQ_EN = 8'h14;

    localparam int BIT_ACK = 15;
    localparam int BIT_TXACT = 14;
    localparam int BIT_BCL = 10;
    localparam int BIT_GC = 9;
    localparam int BIT_TEN = 8;
    localparam int BIT_WCOL = 7;
    localparam int BIT_OV = 6;
    localparam int BIT_DA = 5;
    localparam int BIT_STOP = 4;
    localparam int BIT_START = 3;
    localparam int BIT_UNIMP_HI = 13;
    localparam int BIT_UNIMP_LO = 11;

    localparam int IRQ_BCL = 0;
    localparam int IRQ_WCOL = 1;
    localparam int IRQ_OV = 2;
    localparam int IRQ_STOP = 3;
    localparam int IRQ_START = 4;

    localparam logic [STAT_W-1:0] STATUS_RESET = 16'h0000;
    localparam logic [BYTE_W-1:0] BYTE_RESET = 8'h00;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 5'h00;
    localparam logic [DATA_W-1:0] WORD_ZERO = 32'h0000_0000;
endpackage

// [rtl/bus_cond_detect.sv]
// synchronises the bus pins and finds start and stop conditions
`timescale 1ns/1ps
module bus_cond_detect (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic start_det,
    output logic stop_det
);
    logic scl_meta, scl_sync, sda_meta, sda_sync, sda_prev;

    // first stage feeds only the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scl_meta <= 1'b1;
            scl_sync <= 1'b1;
            sda_meta <= 1'b1;
            sda_sync <= 1'b1;
            sda_prev <= 1'b1;
        end else begin
            scl_meta <= scl_in;
            scl_sync <= scl_meta;
            sda_meta <= sda_in;
            sda_sync <= sda_meta;
            sda_prev <= sda_sync;
        end
    end

    // data edge while clock is high marks a condition
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_det <= 1'b0;
            stop_det <= 1'b0;
        end else begin
            start_det <= scl_sync & sda_prev & ~sda_sync;
            stop_det <= scl_sync & ~sda_prev & sda_sync;
        end
    end
endmodule

// [rtl/sticky_bank.sv]
// bank of sticky event bits, set wins over clear
`timescale 1ns/1ps
module sticky_bank #(
    parameter int WIDTH = 5
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [WIDTH-1:0] set_pulse,
    input wire logic [WIDTH-1:0] clear_mask,
    output logic [WIDTH-1:0] flags
);
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    flags[i] <= 1'b0;
                end else if (set_pulse[i]) begin
                    flags[i] <= 1'b1;
                end else if (clear_mask[i]) begin
                    flags[i] <= 1'b0;
                end
            end
        end
    endgenerate
endmodule

// [rtl/i2c_status_flag_logic.sv]
// status flags of the two-wire port with apb access and interrupt
// Operation
// RQ1 - ack slot end records slave ack result
// RQ2 - transmit active from start to ack end
// RQ3 - master collision sets sticky flag, software clears
// RQ4 - general call match sets, stop clears
// RQ5 - ten-bit second byte match sets, stop clears
// RQ6 - busy transmit write discarded, collision flag set
// RQ7 - byte into full buffer sets overflow
// RQ8 - address match clears, slave data sets
// RQ9 - stop flag true only if stop last
// RQ10 - start flag set by start, cleared by stop
// RQ11 - bits 13 to 11 zero, reset all zero
//
// The address map and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
module i2c_status_flag_logic (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic master_mode,
    input wire logic port_busy,
    input wire logic master_tx_start,
    input wire logic ack_slot_end,
    input wire logic ack_bit_in,
    input wire logic collision_detect,
    input wire logic gen_call_match,
    input wire logic ten_bit_match,
    input wire logic addr_match,
    input wire logic slave_data_rx,
    input wire logic rx_byte_done,
    input wire logic [7:0] rx_byte,
    output logic [7:0] tx_byte,
    output logic tx_load,
    output logic irq
);
    logic ack_result_flag, master_tx_active, bus_collision_flag;
    logic general_call_flag, ten_bit_match_flag, write_collision_flag;
    logic receive_overflow_flag, data_addr_flag, stop_flag, start_flag;
    logic rx_full;
    logic [7:0] receive_buffer_reg;
    logic start_det, stop_det;
    logic [15:0] status_word;
    logic [4:0] irq_en, irq_flags, irq_set, irq_clr;
    logic setup, access, wr_acc, rd_setup, addr_hit, err_q;
    logic wr_status, wr_tx, rd_rx;
    logic [31:0] next_rdata;

    bus_cond_detect u_cond (
        .pclk(pclk),
        .presetn(presetn),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .start_det(start_det),
        .stop_det(stop_det)
    );

    // apb phases; zero wait states keep the master simple
    assign setup = psel & ~penable;
    assign access = psel & penable;
    assign wr_acc = access & pwrite;
    assign rd_setup = setup & ~pwrite;
    assign pready = 1'b1;
    assign pslverr = access & err_q;
    assign wr_status = wr_acc & (paddr == i2c_flag_pkg::OFS_STATUS);
    assign wr_tx = wr_acc & (paddr == i2c_flag_pkg::OFS_TX_BUF);
    assign rd_rx = access & ~pwrite & (paddr == i2c_flag_pkg::OFS_RX_BUF);

    always_comb begin
        if (paddr == i2c_flag_pkg::OFS_STATUS) begin
            addr_hit = 1'b1;
        end else if (paddr == i2c_flag_pkg::OFS_TX_BUF) begin
            addr_hit = 1'b1;
        end else if (paddr == i2c_flag_pkg::OFS_RX_BUF) begin
            addr_hit = 1'b1;
        end else if (paddr == i2c_flag_pkg::OFS_IRQ_STAT) begin
            addr_hit = 1'b1;
        end else if (paddr == i2c_flag_pkg::OFS_IRQ_CLR) begin
            addr_hit = 1'b1;
        end else if (paddr == i2c_flag_pkg::OFS_IRQ_EN) begin
            addr_hit = 1'b1;
        end else begin
            addr_hit = 1'b0;
        end
    end

    // status word; unlisted bits stay zero
    always_comb begin
        status_word = i2c_flag_pkg::STATUS_RESET; // RQ11
        status_word[i2c_flag_pkg::BIT_ACK] = ack_result_flag;
        status_word[i2c_flag_pkg::BIT_TXACT] = master_tx_active;
        status_word[i2c_flag_pkg::BIT_BCL] = bus_collision_flag;
        status_word[i2c_flag_pkg::BIT_GC] = general_call_flag;
        status_word[i2c_flag_pkg::BIT_TEN] = ten_bit_match_flag;
        status_word[i2c_flag_pkg::BIT_WCOL] = write_collision_flag;
        status_word[i2c_flag_pkg::BIT_OV] = receive_overflow_flag;
        status_word[i2c_flag_pkg::BIT_DA] = data_addr_flag;
        status_word[i2c_flag_pkg::BIT_STOP] = stop_flag;
        status_word[i2c_flag_pkg::BIT_START] = start_flag;
    end

    always_comb begin
        next_rdata = i2c_flag_pkg::WORD_ZERO;
        if (paddr == i2c_flag_pkg::OFS_STATUS) begin
            next_rdata[15:0] = status_word;
        end else if (paddr == i2c_flag_pkg::OFS_TX_BUF) begin
            next_rdata[7:0] = tx_byte;
        end else if (paddr == i2c_flag_pkg::OFS_RX_BUF) begin
            next_rdata[7:0] = receive_buffer_reg;
        end else if (paddr == i2c_flag_pkg::OFS_IRQ_STAT) begin
            next_rdata[4:0] = irq_flags;
        end else if (paddr == i2c_flag_pkg::OFS_IRQ_EN) begin
            next_rdata[4:0] = irq_en;
        end
    end

    // read data is sampled in the setup phase, so it shows the state
    // one cycle before the access edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= i2c_flag_pkg::WORD_ZERO;
            err_q <= 1'b0;
        end else if (setup) begin
            prdata <= rd_setup ? next_rdata : i2c_flag_pkg::WORD_ZERO;
            err_q <= ~addr_hit;
        end
    end

    // ack result only meaningful while transmitting as master
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ack_result_flag <= 1'b0;
        end else if (ack_slot_end && master_tx_active) begin
            ack_result_flag <= ack_bit_in; // RQ1
        end
    end

    // a new start in the ack-end cycle wins so it is not lost
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            master_tx_active <= 1'b0;
        end else if (master_tx_start) begin
            master_tx_active <= 1'b1; // RQ2
        end else if (ack_slot_end) begin
            master_tx_active <= 1'b0; // RQ2
        end
    end

    // software clears by writing zero to the bit; set wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_collision_flag <= 1'b0;
        end else if (collision_detect && master_mode) begin
            bus_collision_flag <= 1'b1; // RQ3
        end else if (wr_status && !pwdata[i2c_flag_pkg::BIT_BCL]) begin
            bus_collision_flag <= 1'b0; // RQ3
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            general_call_flag <= 1'b0;
        end else if (gen_call_match) begin
            general_call_flag <= 1'b1; // RQ4
        end else if (stop_det) begin
            general_call_flag <= 1'b0; // RQ4
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ten_bit_match_flag <= 1'b0;
        end else if (ten_bit_match) begin
            ten_bit_match_flag <= 1'b1; // RQ5
        end else if (stop_det) begin
            ten_bit_match_flag <= 1'b0; // RQ5
        end
    end

    // a busy write is dropped rather than corrupting the byte in flight
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_byte <= i2c_flag_pkg::BYTE_RESET;
            tx_load <= 1'b0;
        end else begin
            tx_load <= wr_tx & ~port_busy; // RQ6
            if (wr_tx && !port_busy) begin
                tx_byte <= pwdata[7:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            write_collision_flag <= 1'b0;
        end else if (wr_tx && port_busy) begin
            write_collision_flag <= 1'b1; // RQ6
        end else if (wr_status && !pwdata[i2c_flag_pkg::BIT_WCOL]) begin
            write_collision_flag <= 1'b0;
        end
    end

    // buffer keeps the older byte on overflow; the new one is lost
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            receive_buffer_reg <= i2c_flag_pkg::BYTE_RESET;
            rx_full <= 1'b0;
        end else if (rx_byte_done && !rx_full) begin
            receive_buffer_reg <= rx_byte;
            rx_full <= 1'b1;
        end else if (rd_rx) begin
            rx_full <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            receive_overflow_flag <= 1'b0;
        end else if (rx_byte_done && rx_full) begin
            receive_overflow_flag <= 1'b1; // RQ7
        end else if (wr_status && !pwdata[i2c_flag_pkg::BIT_OV]) begin
            receive_overflow_flag <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_addr_flag <= 1'b0;
        end else if (addr_match) begin
            data_addr_flag <= 1'b0; // RQ8
        end else if (slave_data_rx) begin
            data_addr_flag <= 1'b1; // RQ8
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stop_flag <= 1'b0;
            start_flag <= 1'b0;
        end else if (stop_det) begin
            stop_flag <= 1'b1; // RQ9
            start_flag <= 1'b0; // RQ10
        end else if (start_det) begin
            stop_flag <= 1'b0; // RQ9
            start_flag <= 1'b1; // RQ10
        end
    end

    // interrupt bank: write-one-to-clear, enable gates the output
    always_comb begin
        irq_set = i2c_flag_pkg::IRQ_RESET;
        irq_set[i2c_flag_pkg::IRQ_BCL] = collision_detect & master_mode;
        irq_set[i2c_flag_pkg::IRQ_WCOL] = wr_tx & port_busy;
        irq_set[i2c_flag_pkg::IRQ_OV] = rx_byte_done & rx_full;
        irq_set[i2c_flag_pkg::IRQ_STOP] = stop_det;
        irq_set[i2c_flag_pkg::IRQ_START] = start_det & ~stop_det;
    end

    assign irq_clr = (wr_acc && paddr == i2c_flag_pkg::OFS_IRQ_CLR) ?
        pwdata[4:0] : i2c_flag_pkg::IRQ_RESET;

    sticky_bank #(
        .WIDTH(i2c_flag_pkg::IRQ_W)
    ) u_irq (
        .pclk(pclk),
        .presetn(presetn),
        .set_pulse(irq_set),
        .clear_mask(irq_clr),
        .flags(irq_flags)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_en <= i2c_flag_pkg::IRQ_RESET;
        end else if (wr_acc && paddr == i2c_flag_pkg::OFS_IRQ_EN) begin
            irq_en <= pwdata[4:0];
        end
    end

    assign irq = |(irq_flags & irq_en);

    a_ack_update: assert property (@(posedge pclk) disable iff (!presetn)
        ack_slot_end && master_tx_active
        |=> ack_result_flag == $past(ack_bit_in)) // RQ1
        else $error("ack flag not updated at ack end");

    a_txact_span: assert property (@(posedge pclk) disable iff (!presetn)
        master_tx_start ##1 !ack_slot_end [*2]
        |-> master_tx_active) // RQ2
        else $error("transmit active dropped before ack end");

    a_txact_clear: assert property (@(posedge pclk) disable iff (!presetn)
        ack_slot_end && !master_tx_start |=> !master_tx_active) // RQ2
        else $error("transmit active not cleared at ack end");

    a_bcl_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        collision_detect && master_mode ##1 !wr_status [*3]
        |-> bus_collision_flag) // RQ3
        else $error("collision flag lost without software clear");

    a_gc_stop: assert property (@(posedge pclk) disable iff (!presetn)
        stop_det && !gen_call_match |=> !general_call_flag) // RQ4
        else $error("general call flag survived stop");

    a_ten_set: assert property (@(posedge pclk) disable iff (!presetn)
        ten_bit_match |=> ten_bit_match_flag) // RQ5
        else $error("ten bit match flag not set");

    a_wcol_drop: assert property (@(posedge pclk) disable iff (!presetn)
        wr_tx && port_busy
        |=> write_collision_flag && !tx_load && $stable(tx_byte)) // RQ6
        else $error("busy write not discarded");

    a_ov_keep: assert property (@(posedge pclk) disable iff (!presetn)
        rx_byte_done && rx_full
        |=> receive_overflow_flag && $stable(receive_buffer_reg)) // RQ7
        else $error("overflow not flagged or buffer overwritten");

    a_da_match: assert property (@(posedge pclk) disable iff (!presetn)
        addr_match |=> !data_addr_flag) // RQ8
        else $error("address match did not clear data flag");

    a_da_data: assert property (@(posedge pclk) disable iff (!presetn)
        slave_data_rx && !addr_match |=> data_addr_flag) // RQ8
        else $error("slave data byte did not set data flag");

    a_stop_last: assert property (@(posedge pclk) disable iff (!presetn)
        start_det && !stop_det |=> !stop_flag && start_flag) // RQ9
        else $error("stop flag set after start");

    a_stop_set: assert property (@(posedge pclk) disable iff (!presetn)
        stop_det |=> stop_flag && !start_flag) // RQ10
        else $error("stop did not set stop flag");

    a_unimp_zero: assert property (@(posedge pclk) disable iff (!presetn)
        rd_setup && paddr == i2c_flag_pkg::OFS_STATUS
        |=> prdata[13:11] == 3'h0 && prdata[31:16] == 16'h0000) // RQ11
        else $error("unimplemented status bits not zero");
endmodule

// [verif/bus_peer_model.sv]
// far-side bus device that makes start, stop and bit clocks
`timescale 1ns/1ps
module bus_peer_model (
    output logic scl,
    output logic sda
);
    // released lines sit at the pull-up level; clock runs only in frames
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end
    // also serves as repeated start when called with scl low
    // the 1 ns lead keeps pin changes off the pclk edges
    task automatic start_cond();
        #1;
        sda = 1'b1;
        #40 scl = 1'b1;
        #40 sda = 1'b0;
        #40 scl = 1'b0;
    endtask
    task automatic clock_bits(input int n);
        #1;
        repeat (n) begin
            #40 scl = 1'b1;
            #40 scl = 1'b0;
        end
    endtask
    task automatic stop_cond();
        #1;
        sda = 1'b0;
        #40 scl = 1'b1;
        #40 sda = 1'b1;
    endtask
endmodule

// [verif/i2c_status_flag_logic_tb.sv]
// self-checking bench for the two-wire port status flags
`timescale 1ns/1ps
module i2c_status_flag_logic_tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr, rx_byte, tx_byte, ev;
    logic [31:0] pwdata, prdata, rd;
    logic scl, sda, irq, tx_load, master_mode, port_busy, ack_bit_in;
    int num_errors, comparisons, loads;
    localparam logic [7:0] TXS = 8'h01, ACK = 8'h02, COL = 8'h04;
    localparam logic [7:0] GC = 8'h08, TEN = 8'h10, ADR = 8'h20;
    localparam logic [7:0] DAT = 8'h40, RXD = 8'h80;

    i2c_status_flag_logic dut (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .scl_in(scl), .sda_in(sda), .master_mode(master_mode),
        .port_busy(port_busy), .master_tx_start(ev[0]),
        .ack_slot_end(ev[1]), .ack_bit_in(ack_bit_in),
        .collision_detect(ev[2]), .gen_call_match(ev[3]),
        .ten_bit_match(ev[4]), .addr_match(ev[5]),
        .slave_data_rx(ev[6]), .rx_byte_done(ev[7]),
        .rx_byte(rx_byte), .tx_byte(tx_byte), .tx_load(tx_load),
        .irq(irq)
    );
    bus_peer_model peer (.scl(scl), .sda(sda));

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        if (tx_load === 1'b1)
            loads <= loads + 1;
    end

    task automatic end_of_test();
        $display("comparisons %0d errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t word %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t bit %b exp %b", $time, got, exp);
        end
    endtask
    // apb master: holds the request until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            num_errors++;
            $display("[FAIL] %0t apb timeout", $time);
            end_of_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic read_chk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk_word(rd, exp);
    endtask
    task automatic pulse(input logic [7:0] m);
        @(posedge pclk);
        ev <= m;
        @(posedge pclk);
        ev <= 8'h00;
    endtask
    // let registered outputs land before looking at them
    task automatic settle(input int n);
        repeat (n) @(posedge pclk);
        @(negedge pclk);
    endtask

    task automatic t_reset();
        read_chk(i2c_flag_pkg::OFS_STATUS, 32'h0000_0000);
        read_chk(i2c_flag_pkg::OFS_IRQ_STAT, 32'h0000_0000);
        read_chk(i2c_flag_pkg::OFS_IRQ_EN, 32'h0000_0000);
        chk_bit(irq, 1'b0);
        apb(1'b0, 8'h18, 32'h0000_0000);
        chk_bit(err, 1'b1);
        $display("done reset");
    endtask
    task automatic t_ack();
        pulse(TXS);
        read_chk(i2c_flag_pkg::OFS_STATUS, 32'h0000_4000);
        ack_bit_in <= 1'b1;
        pulse(ACK);
        read_chk(i2c_flag_pkg::OFS_STATUS, 32'h0000_8000);
        ack_bit_in <= 1'b0;
        pulse(ACK);
        read_chk(i2c_flag_pkg::OFS_STATUS, 32'h0000_8000);
        pulse(TXS);
        read_chk(i2c_flag_pkg::OFS_STATUS, 32'h0000_c000);
        pulse(ACK);
        read_chk(i2c_flag_pkg::OFS_STATUS, 32'h0000_0000);
        $display("done ack");
    endtask
    task automatic t_cond();
        peer.start_cond();
        settle(12);
        read_chk(i2c_flag_pkg::OFS_STATUS, 32'h0000_0008);
        pulse(GC | TEN);
        peer.clock_bits(3);
        peer.start_cond();
        settle(12);
        read_chk(i2c_flag_pkg::OFS_STATUS, 32'h0000_0308);
        peer.clock_bits(2);
        peer.stop_cond();
        settle(12);
        read_chk(i2c_flag_pkg::OFS_STATUS, 32'h0000_0010);
        read_chk(i2c_flag_pkg::OFS_IRQ_STAT, 32'h0000_0018);
        apb(1'b1, i2c_flag_pkg::OFS_IRQ_CLR, 32'h0000_001f);
        read_chk(i2c_flag_pkg::OFS_IRQ_STAT, 32'h0000_0000);
        $display("done conditions");
    endtask
    task automatic t_col();
        master_mode <= 1'b0;
        pulse(COL);
        read_chk(i2c_flag_pkg::OFS_STATUS, 32'h0000_0010);
        master_mode <= 1'b1;
        pulse(COL);
        read_chk(i2c_flag_pkg::OFS_STATUS, 32'h0000_0410);
        apb(1'b1, i2c_flag_pkg::OFS_IRQ_EN, 32'h0000_0001);
        settle(0);
        chk_bit(irq, 1'b1);
        apb(1'b1, i2c_flag_pkg::OFS_IRQ_EN, 32'h0000_0000);
        settle(0);
        chk_bit(irq, 1'b0);
        apb(1'b1, i2c_flag_pkg::OFS_IRQ_EN, 32'h0000_0001);
        apb(1'b1, i2c_flag_pkg::OFS_IRQ_CLR, 32'h0000_0001);
        settle(0);
        chk_bit(irq, 1'b0);
        read_chk(i2c_flag_pkg::OFS_STATUS, 32'h0000_0410);
        apb(1'b1, i2c_flag_pkg::OFS_STATUS, 32'h0000_fbff);
        read_chk(i2c_flag_pkg::OFS_STATUS, 32'h0000_0010);
        master_mode <= 1'b0;
        $display("done collision");
    endtask
    task automatic t_wcol();
        port_busy <= 1'b1;
        apb(1'b1, i2c_flag_pkg::OFS_TX_BUF, 32'h0000_00a5);
        settle(2);
        chk_bit(loads == 0, 1'b1);
        read_chk(i2c_flag_pkg::OFS_STATUS, 32'h0000_0090);
        read_chk(i2c_flag_pkg::OFS_IRQ_STAT, 32'h0000_0002);
        port_busy <= 1'b0;
        apb(1'b1, i2c_flag_pkg::OFS_TX_BUF, 32'h0000_003c);
        settle(2);
        chk_bit(loads == 1, 1'b1);
        chk_word({24'h000000, tx_byte}, 32'h0000_003c);
        apb(1'b1, i2c_flag_pkg::OFS_STATUS, 32'h0000_ff7f);
        read_chk(i2c_flag_pkg::OFS_STATUS, 32'h0000_0010);
        $display("done write collision");
    endtask
    task automatic t_ovf();
        rx_byte <= 8'h5a;
        pulse(RXD);
        rx_byte <= 8'hc3;
        pulse(RXD);
        read_chk(i2c_flag_pkg::OFS_STATUS, 32'h0000_0050);
        read_chk(i2c_flag_pkg::OFS_RX_BUF, 32'h0000_005a);
        read_chk(i2c_flag_pkg::OFS_IRQ_STAT, 32'h0000_0006);
        apb(1'b1, i2c_flag_pkg::OFS_STATUS, 32'h0000_ffbf);
        rx_byte <= 8'h77;
        pulse(RXD);
        read_chk(i2c_flag_pkg::OFS_RX_BUF, 32'h0000_0077);
        read_chk(i2c_flag_pkg::OFS_STATUS, 32'h0000_0010);
        $display("done overflow");
    endtask
    task automatic t_da();
        pulse(DAT);
        read_chk(i2c_flag_pkg::OFS_STATUS, 32'h0000_0030);
        pulse(ADR | DAT);
        read_chk(i2c_flag_pkg::OFS_STATUS, 32'h0000_0010);
        pulse(DAT);
        pulse(ADR);
        read_chk(i2c_flag_pkg::OFS_STATUS, 32'h0000_0010);
        $display("done data address");
    endtask

    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, master_mode, port_busy, ack_bit_in} = '0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        ev = 8'h00;
        rx_byte = 8'h00;
        num_errors = 0;
        comparisons = 0;
        loads = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_ack();
        t_cond();
        t_col();
        t_wcol();
        t_ovf();
        t_da();
        end_of_test();
    end
endmodule
